// ---- verilog/pefs_top.sv ----
// Event flag, enable mask and negotiation status registers of the transceiver.
// Assumes event inputs synchronous to clk_sys and an Avalon-MM master on the bus.
//
// Summary of operation
// - Status bit 4 shows 10BASE-T receive polarity, one means reversed.
// - Flag 10 latches on transmit buffer overflow until written clear.
// - Flag 9 latches on transmit buffer underflow until written clear.
// - Flag 8 latches on idle error counter overflow until written clear.
// - Flag 7 latches on a rising change of the energy detected level.
// - Flag 6 latches when auto-negotiation completes until written clear.
// - Flag 5 latches when a remote fault is seen until written clear.
// - Flag 4 latches when the link goes down until written clear.
// - Flag 3 latches when the partner acknowledges until written clear.
// - Flag 2 latches on parallel detect or master/slave fault.
// - Flag 1 latches when a negotiation page arrives until written clear.
// - Enable bits 10 to 1 mask their flags; all reset to zero.
// - Bits 15 to 11 and bit 0 are reserved and read zero.
// - Special status bit 12 shows negotiation done.
// - Reading special status clears nothing.
// - Special status bits 4:2 hold the speed and duplex code.
// - Speed and duplex field loads from the negotiation outcome.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
module pefs_top #(
    parameter int NUM_FLAGS = 10
) (
    // Clock and reset.
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    // Avalon-MM slave.
    input  wire logic [pefs_pkg::PEFS_ADDR_W+1:0]   avs_address,
    input  wire logic                               avs_read,
    input  wire logic                               avs_write,
    input  wire logic [31:0]                        avs_writedata,
    input  wire logic [3:0]                         avs_byteenable,
    output logic      [31:0]                        avs_readdata,
    output logic                                    avs_waitrequest,
    output logic      [1:0]                         avs_response,
    // Event sources from the transceiver core.
    input  wire logic                               tx_buf_overflow,
    input  wire logic                               tx_buf_underflow,
    input  wire logic                               idle_err_overflow,
    input  wire logic                               energy_detected,
    input  wire logic                               negotiation_done,
    input  wire logic                               remote_fault,
    input  wire logic                               link_up,
    input  wire logic                               partner_ack,
    input  wire logic                               detect_config_fault,
    input  wire logic                               page_received,
    // Status sources.
    input  wire logic                               line_polarity_reversed,
    input  wire logic                               result_valid,
    input  wire logic [2:0]                         resolved_speed_duplex,
    // Interrupt request.
    output logic                                    irq_reg
);
    import pefs_pkg::*;

    // The flag field is bits 10 to 1 of a sixteen-bit word, so no other count fits.
    if (NUM_FLAGS != PEFS_FLAG_HI - PEFS_FLAG_LO + 1) begin : g_bad_num_flags
        $error("NUM_FLAGS must match the ten flag bits");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event edges and latched flags.

    logic [NUM_FLAGS-1:0] src_level;
    logic [NUM_FLAGS-1:0] set_pulse;
    logic [NUM_FLAGS-1:0] flag_bits;
    logic [NUM_FLAGS-1:0] clear_pulse;
    // Flag and mask words as software sees them.
    logic [15:0]          event_source_flags;
    logic [15:0]          event_enable_mask_reg;
    logic                 flag_write;

    // Source levels, index 0 is flag bit 1. Link down is the fall of link_up.
    assign src_level = {tx_buf_overflow, tx_buf_underflow, idle_err_overflow,
                        energy_detected, negotiation_done, remote_fault,
                        ~link_up, partner_ack, detect_config_fault,
                        page_received};

    // each source sets its own latched flag on a rising edge.
    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            pefs_edge u_edge (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .level_in   (src_level[i]),
                .rise_pulse (set_pulse[i])
            );
            pefs_flag u_flag (
                .clk_sys     (clk_sys),
                .rst         (rst),
                .set_pulse   (set_pulse[i]),
                .clear_pulse (clear_pulse[i]),
                .flag_reg    (flag_bits[i])
            );
        end
    endgenerate

    assign event_source_flags = {5'h00, flag_bits, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then a one-cycle acknowledge.
    // The wait cycle lets read data come straight from a flop; the price is that
    // back-to-back requests cost three cycles each. A request that is raised in the
    // recovery cycle is not lost: it is taken once the slave is idle again.
    // Partial writes that miss either low byte lane are ignored as a whole.

    pefs_state_e          state_reg;
    logic [PEFS_ADDR_W-1:0] word_idx;
    logic                 hit_pol;
    logic                 hit_flags;
    logic                 hit_mask;
    logic                 hit_spec;
    logic                 hit_any;
    logic                 wr_lo;
    logic [15:0]          rd_word;
    logic                 pol_reg;
    logic                 neg_done_reg;
    logic [2:0]           speed_reg;

    assign word_idx = avs_address[PEFS_ADDR_W+1:2];

    // Address decode.
    // An index outside the four registers hits nothing and answers with an error code.
    always_comb begin
        hit_pol   = 1'b0;
        hit_flags = 1'b0;
        hit_mask  = 1'b0;
        hit_spec  = 1'b0;
        if (word_idx == PEFS_IDX_POLARITY) begin
            hit_pol = 1'b1;
        end else if (word_idx == PEFS_IDX_FLAGS) begin
            hit_flags = 1'b1;
        end else if (word_idx == PEFS_IDX_MASK) begin
            hit_mask = 1'b1;
        end else if (word_idx == PEFS_IDX_SPECIAL) begin
            hit_spec = 1'b1;
        end
    end

    assign hit_any = hit_pol | hit_flags | hit_mask | hit_spec;
    // Writes take effect in the acknowledge cycle, when waitrequest is low.
    assign wr_lo      = (state_reg == PEFS_ACK) && avs_write && (&avs_byteenable[1:0]);
    assign flag_write = wr_lo && hit_flags;
    assign clear_pulse = flag_write ? avs_writedata[PEFS_FLAG_HI:PEFS_FLAG_LO]
                                    : '0;

    // Read data mux; reads have no side effect on status.
    always_comb begin
        rd_word = 16'h0000;
        if (hit_pol) begin
            rd_word[PEFS_POL_BIT] = pol_reg;
        end else if (hit_flags) begin
            rd_word = event_source_flags;
        end else if (hit_mask) begin
            rd_word = event_enable_mask_reg;
        end else if (hit_spec) begin
            rd_word[PEFS_NEG_DONE]             = neg_done_reg;
            rd_word[PEFS_SPD_HI:PEFS_SPD_LO]   = speed_reg;
        end
    end

    // Handshake state: IDLE sees a request, ACK drops waitrequest, DONE lets it go.
    // DONE gives the master one edge to drop its request before IDLE looks again.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= PEFS_IDLE;
        end else begin
            case (state_reg)
                PEFS_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_reg <= PEFS_ACK;
                    end
                end
                PEFS_ACK: begin
                    state_reg <= PEFS_DONE;
                end
                default: begin
                    state_reg <= PEFS_IDLE;
                end
            endcase
        end
    end

    // Waitrequest, read data and response come from flops.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= 2'h0;
        end else begin
            avs_waitrequest <= !((state_reg == PEFS_IDLE) && (avs_read || avs_write));
            if ((state_reg == PEFS_IDLE) && avs_read) begin
                avs_readdata <= {16'h0000, rd_word};
            end
            if ((state_reg == PEFS_IDLE) && (avs_read || avs_write)) begin
                avs_response <= hit_any ? 2'h0 : 2'h3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mask and status registers.

    // enable mask, writable bits 10 to 1 only.
    // Reserved bits are cut on the way in, so they can never read back as one.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            event_enable_mask_reg <= PEFS_MASK_RST;
        end else if (wr_lo && hit_mask) begin
            event_enable_mask_reg <= avs_writedata[15:0] & PEFS_FLAG_VALID;
        end
    end

    // polarity and done indication track the core.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pol_reg      <= 1'b0;
            neg_done_reg <= 1'b0;
        end else begin
            pol_reg      <= line_polarity_reversed;
            neg_done_reg <= negotiation_done;
        end
    end

    // speed field loads the negotiation result, encoding.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            speed_reg <= PEFS_SPD_RST;
        end else if (result_valid) begin
            speed_reg <= resolved_speed_duplex;
        end
    end

    // interrupt from any enabled flag.
    // Registered so the request is glitch free; it trails its flag by one cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(event_source_flags & event_enable_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Interrupt, flag, speed and bus timing checks; all share the system clock and rest in reset.
    a_irq_follows_flags: assert property (
        |(event_source_flags & event_enable_mask_reg) |=> irq_reg)
        else $error("irq not raised for enabled flag");
    a_irq_drops: assert property (
        !(|(event_source_flags & event_enable_mask_reg)) |=> !irq_reg)
        else $error("irq high with no enabled flag");
    a_flag_sets_edge: assert property (
        set_pulse[9] |=> flag_bits[9])
        else $error("overflow flag not latched");
    a_flag_holds_high: assert property (
        flag_bits[5] && !clear_pulse[5] |=> flag_bits[5])
        else $error("flag lost without clear");
    a_link_down_set: assert property (
        $fell(link_up) |=> flag_bits[3])
        else $error("link down flag not set");
    a_energy_rise_set: assert property (
        $rose(energy_detected) |=> flag_bits[6])
        else $error("energy flag not set");
    a_reserved_zero: assert property (
        (event_source_flags & ~PEFS_FLAG_VALID) == 16'h0000
        && (event_enable_mask_reg & ~PEFS_FLAG_VALID) == 16'h0000)
        else $error("reserved bit nonzero");
    a_speed_loads: assert property (
        result_valid |=> speed_reg == $past(resolved_speed_duplex))
        else $error("speed field not loaded");
    a_read_no_clear: assert property (
        (state_reg == PEFS_ACK) && avs_read |=> ($past(flag_bits) & ~flag_bits) == '0)
        else $error("read cleared a flag");
    a_ack_one_wait: assert property (
        (state_reg == PEFS_IDLE) && (avs_read || avs_write) |=> !avs_waitrequest ##1
        avs_waitrequest)
        else $error("bus acknowledge timing wrong");

    // Bus handshake and response code.
    a_done_waits: assert property (
        (state_reg == PEFS_DONE) |-> avs_waitrequest)
        else $error("request accepted in the recovery cycle");
    a_resp_unmapped: assert property (
        (state_reg == PEFS_IDLE) && (avs_read || avs_write) && !hit_any
            |=> avs_response == 2'h3)
        else $error("unmapped access not flagged");
    a_resp_mapped: assert property (
        (state_reg == PEFS_IDLE) && (avs_read || avs_write) && hit_any
            |=> avs_response == 2'h0)
        else $error("mapped access flagged as error");
    a_readdata_upper: assert property (
        avs_readdata[31:16] == 16'h0000)
        else $error("upper read data nonzero");

    // Register contents: polarity and done bits show their core level one cycle late; speed holds and mask loads.
    a_polarity_tracks: assert property (
        1'b1 |=> pol_reg == $past(line_polarity_reversed))
        else $error("polarity bit does not follow the core");
    a_done_tracks: assert property (
        1'b1 |=> neg_done_reg == $past(negotiation_done))
        else $error("negotiation done bit does not follow the core");
    a_speed_holds: assert property (
        !result_valid |=> $stable(speed_reg))
        else $error("speed field changed without a result");
    a_mask_write: assert property (
        wr_lo && hit_mask |=> {16'h0000, event_enable_mask_reg}
            == ($past(avs_writedata) & {16'h0000, PEFS_FLAG_VALID}))
        else $error("mask write not taken");

    // every flag latches on its edge, clears by a one, holds otherwise.
    // A level held high sets its flag once only, so a stuck source cannot refill it.
    for (genvar j = 0; j < NUM_FLAGS; j++) begin : g_flag_chk
        a_flag_latch: assert property (@(posedge clk_sys) disable iff (rst)
            set_pulse[j] |=> flag_bits[j])
            else $error("flag not latched on its event");
        a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
            clear_pulse[j] && !set_pulse[j] |=> !flag_bits[j])
            else $error("flag not cleared by a write of one");
        a_flag_keep: assert property (@(posedge clk_sys) disable iff (rst)
            flag_bits[j] && !clear_pulse[j] |=> flag_bits[j])
            else $error("flag dropped without a write of one");
        a_edge_once: assert property (@(posedge clk_sys) disable iff (rst)
            src_level[j] && $past(src_level[j]) |-> !set_pulse[j])
            else $error("held level set its flag again");
    end

    // Scenarios worth seeing: clears, interrupt rise, set against clear, unmapped reads, mask writes.
    c_flag_clear: cover property (flag_write && |clear_pulse);
    c_irq_rise: cover property ($rose(irq_reg));
    c_set_and_clear: cover property (|(set_pulse & clear_pulse));
    c_bad_addr: cover property (avs_read && !hit_any);
    c_mask_write: cover property (wr_lo && hit_mask);
endmodule

// ---- verilog/pefs_pkg.sv ----
// Package of the transceiver event flag and status register group.
// Assumes a 32-bit Avalon-MM slave with word registers at index*4 byte addresses.
package pefs_pkg;
    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0] PEFS_IDX_POLARITY = 8'h1b;
    localparam logic [7:0] PEFS_IDX_FLAGS    = 8'h1d;
    localparam logic [7:0] PEFS_IDX_MASK     = 8'h1e;
    localparam logic [7:0] PEFS_IDX_SPECIAL  = 8'h1f;
    localparam int         PEFS_ADDR_W       = 8;
    // Field positions.
    localparam int PEFS_POL_BIT     = 4;
    localparam int PEFS_FLAG_LO     = 1;
    localparam int PEFS_FLAG_HI     = 10;
    localparam int PEFS_NEG_DONE    = 12;
    localparam int PEFS_SPD_LO      = 2;
    localparam int PEFS_SPD_HI      = 4;
    // Valid flag bits: 10 down to 1, others reserved and read as zero.
    localparam logic [15:0] PEFS_FLAG_VALID = 16'h07fe;
    localparam logic [15:0] PEFS_FLAG_RST   = 16'h0000;
    localparam logic [15:0] PEFS_MASK_RST   = 16'h0000;
    localparam logic [2:0]  PEFS_SPD_RST    = 3'h0;
    // Speed and duplex codes.
    localparam logic [2:0] PEFS_SPD_10_HD  = 3'h1;
    localparam logic [2:0] PEFS_SPD_10_FD  = 3'h5;
    localparam logic [2:0] PEFS_SPD_100_HD = 3'h2;
    localparam logic [2:0] PEFS_SPD_100_FD = 3'h6;
    // Bus slave states.
    typedef enum logic [2:0] {
        PEFS_IDLE = 3'b001,
        PEFS_ACK  = 3'b010,
        PEFS_DONE = 3'b100
    } pefs_state_e;
endpackage

// ---- verilog/pefs_edge.sv ----
// Rising edge detector for one event source level.
// Assumes the level is synchronous to clk_sys.
`timescale 1ns/100ps
module pefs_edge (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Level in, pulse out.
    input  wire logic level_in,
    output logic      rise_pulse
);
    logic level_reg;

    // Previous level, so a level held across reset does not fire.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_reg <= 1'b1;
        end else begin
            level_reg <= level_in;
        end
    end

    // One cycle pulse on the low to high change.
    assign rise_pulse = level_in & ~level_reg;
endmodule

// ---- verilog/pefs_flag.sv ----
// One latched event flag: set by hardware, cleared by a software write of one.
// Assumes set and clear are single-cycle pulses on clk_sys.
`timescale 1ns/100ps
module pefs_flag (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Set and clear.
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag_reg
);
    // The set wins over the clear so no event is lost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (set_pulse) begin
            flag_reg <= 1'b1;
        end else if (clear_pulse) begin
            flag_reg <= 1'b0;
        end
    end
endmodule

// ---- testbench/pefs_host.sv ----
// Avalon-MM master model standing in for the management host.
// Assumes a slave that answers a request by dropping waitrequest.
`timescale 1ns/100ps
module pefs_host (
    // Clock.
    input  wire logic                             clk_sys,
    // Avalon-MM master side.
    output logic [pefs_pkg::PEFS_ADDR_W+1:0]      avs_address,
    output logic                                  avs_read,
    output logic                                  avs_write,
    output logic [31:0]                           avs_writedata,
    output logic [3:0]                            avs_byteenable,
    input  wire logic                             avs_waitrequest
);
    import pefs_pkg::*;
    // Idle bus at time zero.
    initial begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'hf;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One access; released lines show the inverse so stale values never pass.
    task automatic access(input logic [9:0] a, input logic wr, input logic [31:0] d,
                          input logic [3:0] be = 4'hf);
        @(posedge clk_sys);
        avs_address    <= a;
        avs_byteenable <= be;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask
endmodule

// ---- testbench/pefs_tb.sv ----
// Self-checking bench of the event flag and status register group.
// Assumes the host model drives the bus and this module drives all event sources.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module phy_event_flags_and_status_tb;
    import pefs_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [10:1] src       = '0;
    logic        neg_lvl   = 1'b0;
    logic        pol       = 1'b0;
    logic        res_valid = 1'b0;
    logic [2:0]  spd       = 3'h0;
    logic        irq;
    logic [33:0] q[$];
    logic [33:0] exp_rd;
    logic [31:0] seed      = 32'h24;
    int          n_fail    = 0;
    int          checked   = 0;
    int          cycles    = 0;
    // Clock at 200 MHz.
    always #2.5 clk_sys = ~clk_sys;
    pefs_host host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));
    pefs_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .tx_buf_overflow(src[10]), .tx_buf_underflow(src[9]),
        .idle_err_overflow(src[8]), .energy_detected(src[7]),
        .negotiation_done(src[6] | neg_lvl), .remote_fault(src[5]), .link_up(~src[4]),
        .partner_ack(src[3]), .detect_config_fault(src[2]), .page_received(src[1]),
        .line_polarity_reversed(pol), .result_valid(res_valid),
        .resolved_speed_duplex(spd), .irq_reg(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict in one place, reached by the end of tests or by the timeout.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // A read notes its expected {response, data}; the monitor compares it.
    task automatic rd(input logic [7:0] idx, input logic [33:0] e);
        q.push_back(e);
        host.access({idx, 2'b00}, 1'b0, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.access({idx, 2'b00}, 1'b1, d);
    endtask
    // One-cycle pulse on an event source; source 4 is a drop of the link level.
    task automatic pulse(input int i);
        @(posedge clk_sys) src[i] <= 1'b1;
        @(posedge clk_sys) src[i] <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Read data are taken at the edge where waitrequest is seen low.
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            exp_rd = q.pop_front();
            `CHK("readback", exp_rd, {avs_response, avs_readdata})
        end
    end
    // Hang guard; the tests take well under two thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [2:0]  codes [4];
        codes = '{PEFS_SPD_10_HD, PEFS_SPD_10_FD, PEFS_SPD_100_HD, PEFS_SPD_100_FD};
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(PEFS_IDX_FLAGS, '0);
        rd(PEFS_IDX_MASK, '0);
        rd(PEFS_IDX_SPECIAL, '0);
        @(posedge clk_sys) pol <= 1'b1;
        rd(PEFS_IDX_POLARITY, 34'h10);
        $display("test reset_and_polarity done");
        // Every source latches, survives a write of zeros, clears on a write of one.
        for (int i = 1; i <= 10; i++) begin
            pulse(i);
            wr(PEFS_IDX_FLAGS, 32'hf801);
            rd(PEFS_IDX_FLAGS, 34'(1 << i));
            wr(PEFS_IDX_FLAGS, 32'(1 << i));
            rd(PEFS_IDX_FLAGS, '0);
        end
        $display("test flags done");
        repeat (4) begin
            r = xs();
            wr(PEFS_IDX_MASK, r);
            rd(PEFS_IDX_MASK, {2'b00, r & 32'h07fe});
        end
        wr(PEFS_IDX_MASK, 32'h20);
        pulse(5);
        `CHK("irq_on", 1'b1, irq)
        wr(PEFS_IDX_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        `CHK("irq_masked", 1'b0, irq)
        wr(PEFS_IDX_MASK, 32'h20);
        wr(PEFS_IDX_FLAGS, 32'h20);
        repeat (2) @(posedge clk_sys);
        `CHK("irq_cleared", 1'b0, irq)
        $display("test mask_and_irq done");
        @(posedge clk_sys) neg_lvl <= 1'b1;
        rd(PEFS_IDX_SPECIAL, 34'h1000);
        rd(PEFS_IDX_SPECIAL, 34'h1000);
        rd(PEFS_IDX_FLAGS, 34'h40);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys) spd <= codes[k];
            res_valid <= 1'b1;
            @(posedge clk_sys) res_valid <= 1'b0;
            spd <= codes[xs() % 4];
            rd(PEFS_IDX_SPECIAL, 34'h1000 | 34'(codes[k]) << 2);
        end
        $display("test special_status done");
        rd(8'h1c, {2'b11, 32'h0});
        wr(8'h1c, 32'hffff);
        // A mask write missing a low byte lane must leave the mask alone.
        host.access({PEFS_IDX_MASK, 2'b00}, 1'b1, 32'hffff, 4'hc);
        rd(PEFS_IDX_MASK, 34'h20);
        $display("test unmapped done");
        close_out();
    end
endmodule
